// ==== common/fchpl_params.svh ====
`ifndef FCHPL_PARAMS_SVH
`define FCHPL_PARAMS_SVH
// Address and data widths of the card pins
`define FCHPL_ADDR_W      11
`define FCHPL_DATA_W      16
`define FCHPL_DISK_ADDR_W 3
`define FCHPL_LANE_W      8
// Mode codes
`define FCHPL_MODE_MEM    2'h0
`define FCHPL_MODE_IO     2'h1
`define FCHPL_MODE_DISK   2'h2
// Strobe timing at 200 MHz: address setup and strobe width
`define FCHPL_CLK_PS      5000
`define FCHPL_SETUP_NS    30
`define FCHPL_STROBE_NS   150
`define FCHPL_SETUP_CYC   ((`FCHPL_SETUP_NS * 1000 + `FCHPL_CLK_PS - 1) / `FCHPL_CLK_PS)
`define FCHPL_STROBE_CYC  ((`FCHPL_STROBE_NS * 1000 + `FCHPL_CLK_PS - 1) / `FCHPL_CLK_PS)
`define FCHPL_CNT_W       8
// Synchroniser reset: acknowledge, status and detect pins start idle high,
// so no false acknowledge or insert is seen just after reset
`define FCHPL_SYNC_RST    22'h00003E
`endif

// ==== common/fchpl_pkg.sv ====
package fchpl_pkg;
  typedef enum logic [1:0] {
    FCHPL_MEM  = 2'h0,
    FCHPL_IO   = 2'h1,
    FCHPL_DISK = 2'h2
  } fchpl_mode_t;

  typedef enum logic [1:0] {
    FCHPL_WORD = 2'h0,
    FCHPL_BYTE = 2'h1,
    FCHPL_ODD  = 2'h2
  } fchpl_width_t;

  typedef struct packed {
    logic [10:0] addr;
    logic        attr;
    fchpl_width_t width;
  } fchpl_req_t;

  typedef struct packed {
    logic battery_one;
    logic battery_two;
    logic status_change;
    logic inserted;
    logic slave_present;
    logic diag_pass;
  } fchpl_stat_t;
endpackage : fchpl_pkg

// ==== src/fchpl_host.sv ====
`timescale 1ns/1ps
`include "fchpl_params.svh"
module fchpl_host
  import fchpl_pkg::*;
(
  input  wire logic        clock,             // System clock
  input  wire logic        rstn,              // Async reset, active low
  input  wire fchpl_mode_t mode,              // Access personality
  input  wire logic        if_ready,          // Card interface set up
  input  wire logic        is_master,         // Strap: disk drive master
  input  wire logic        alt_regs,          // Disk: alternate registers
  input  wire logic        req_valid,         // Read request
  output logic             req_ready,         // Request accepted
  input  wire fchpl_req_t  req,               // Read address and width
  output logic             rsp_valid,         // Read data valid pulse
  output logic [15:0]      rsp_data,          // Read data
  output logic             rsp_ack_seen,      // Acknowledge seen in I/O
  output fchpl_stat_t      stat,              // Synchronised status
  output logic [10:0]      addr_o,            // Card address
  output logic             card_select_low_lane_n,  // First select
  output logic             card_select_high_lane_n, // Second select
  output logic             io_read_strobe_n,  // I/O read strobe
  output logic             mem_read_n,        // Memory read strobe
  output logic             disk_mode_select_n, // Mode select pin
  output logic             attr_select_n,     // Attribute select
  output logic             master_slave_select_n,   // Cable select out
  output logic             master_slave_select_oe_n, // Low while driven
  input  wire logic [15:0] data_i,            // Data bus in
  input  wire logic        input_acknowledge_n, // Card acknowledge
  input  wire logic        battery_status_one, // Pin 46 level
  input  wire logic        battery_status_two, // Pin 45 level
  input  wire logic        card_detect_one_n, // Detect one
  input  wire logic        card_detect_two_n  // Detect two
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [21:0] s1_r;
  logic [21:0] s2_r;
  wire  [21:0] pins = {data_i, input_acknowledge_n, battery_status_one,
                       battery_status_two, card_detect_one_n,
                       card_detect_two_n, 1'b0};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_r <= `FCHPL_SYNC_RST;
      s2_r <= `FCHPL_SYNC_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire [15:0] data_s = s2_r[21:6];
  wire        ack_s  = s2_r[5];
  wire        battery_status_one_s = s2_r[4];
  wire        battery_status_two_s = s2_r[3];
  wire        cd1_s  = s2_r[2];
  wire        cd2_s  = s2_r[1];

  // ------------------------------------------------------------
  // Status decode
  // ------------------------------------------------------------
  always_comb begin
    stat.battery_one   = (mode == FCHPL_MEM) & battery_status_one_s;
    stat.battery_two   = (mode == FCHPL_MEM) & battery_status_two_s;
    stat.status_change = (mode == FCHPL_IO) & ~battery_status_one_s;
    stat.inserted      = ~cd1_s & ~cd2_s;
    stat.slave_present = (mode == FCHPL_DISK) & ~battery_status_two_s;
    stat.diag_pass     = (mode == FCHPL_DISK) & ~battery_status_one_s;
  end
  // Audio line in I/O mode (battery_status_two_s) carries nothing, so it is not used

  // ------------------------------------------------------------
  // Lane and select decode
  // ------------------------------------------------------------
  function automatic logic [1:0] lane_sel(input fchpl_width_t w);
    case (w)
      FCHPL_WORD: lane_sel = 2'h0;
      FCHPL_BYTE: lane_sel = 2'h2;
      FCHPL_ODD:  lane_sel = 2'h1;
      default:    lane_sel = 2'h3;
    endcase
  endfunction : lane_sel

  typedef enum logic [1:0] {
    FCHPL_IDLE   = 2'h0,
    FCHPL_SETUP  = 2'h1,
    FCHPL_STROBE = 2'h2
  } fchpl_state_t;

  fchpl_state_t       st_r, st_nxt;
  logic [7:0]         cnt_r;
  fchpl_req_t         req_r;
  logic               ack_r;

  wire disk   = (mode == FCHPL_DISK);
  wire io_rd  = (mode != FCHPL_MEM);
  wire gate   = if_ready | (mode == FCHPL_MEM);
  wire [1:0] sel_pc   = lane_sel(req_r.width);
  wire [1:0] sel_disk = alt_regs ? 2'h1 : 2'h2;
  wire [1:0] sel_n    = disk ? sel_disk : sel_pc;
  wire active = (st_r != FCHPL_IDLE);
  wire cnt_done = (cnt_r == 8'h00);

  assign req_ready = (st_r == FCHPL_IDLE) & gate;
  assign addr_o = disk ? {8'h00, req_r.addr[2:0]} : req_r.addr;
  assign card_select_low_lane_n  = active ? sel_n[0] : 1'b1;
  assign card_select_high_lane_n = active ? sel_n[1] : 1'b1;
  assign io_read_strobe_n = ~((st_r == FCHPL_STROBE) & io_rd);
  assign mem_read_n       = ~((st_r == FCHPL_STROBE) & ~io_rd);
  assign disk_mode_select_n = ~disk;
  assign attr_select_n = (mode == FCHPL_IO) ? 1'b0 :
                         disk ? 1'b1 : ~req_r.attr;
  assign master_slave_select_n    = 1'b0;
  assign master_slave_select_oe_n = ~(disk & is_master);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FCHPL_IDLE:   if (req_valid && gate) st_nxt = FCHPL_SETUP;
      FCHPL_SETUP:  if (cnt_done) st_nxt = FCHPL_STROBE;
      FCHPL_STROBE: if (cnt_done) st_nxt = FCHPL_IDLE;
      default:      st_nxt = FCHPL_IDLE;
    endcase
  end

  localparam logic [7:0] SETUP_C  = 8'(`FCHPL_SETUP_CYC - 1);
  localparam logic [7:0] STROBE_C = 8'(`FCHPL_STROBE_CYC - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r  <= FCHPL_IDLE;
      cnt_r <= 8'h00;
      req_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == FCHPL_IDLE && st_nxt == FCHPL_SETUP) begin
        req_r <= req;
        cnt_r <= SETUP_C;
      end else if (st_r == FCHPL_SETUP && cnt_done) begin
        cnt_r <= STROBE_C;
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Data is captured at the strobe end; lanes per width
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_valid    <= 1'b0;
      rsp_data     <= 16'h0000;
      rsp_ack_seen <= 1'b0;
      ack_r        <= 1'b0;
    end else begin
      rsp_valid <= (st_r == FCHPL_STROBE) & cnt_done;
      if (st_r == FCHPL_SETUP)
        ack_r <= 1'b0;
      else if (st_r == FCHPL_STROBE && mode == FCHPL_IO && !ack_s)
        ack_r <= 1'b1;
      if ((st_r == FCHPL_STROBE) && cnt_done) begin
        rsp_ack_seen <= ack_r | ((mode == FCHPL_IO) & ~ack_s);
        case (req_r.width)
          // A0 picks the byte inside the card; it always lands low
          FCHPL_BYTE: rsp_data <= {8'h00, data_s[7:0]};
          FCHPL_ODD:  rsp_data <= {8'h00, data_s[15:8]};
          default:    rsp_data <= data_s;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  disk_addr_hi_a: assert property (
    @(posedge clock) disable iff (!rstn)
    disk |-> addr_o[10:3] == 8'h00)
    else $error("disk mode upper address not grounded");
  no_strobe_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (st_r == FCHPL_IDLE && !gate) |=> st_r == FCHPL_IDLE)
    else $error("strobe started before interface ready");
  mem_no_ior_a: assert property (
    @(posedge clock) disable iff (!rstn)
    mode == FCHPL_MEM |-> io_read_strobe_n)
    else $error("io read strobe in memory mode");
  word_sel_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (st_r == FCHPL_STROBE && !disk && req_r.width == FCHPL_WORD)
      |-> !card_select_low_lane_n && !card_select_high_lane_n)
    else $error("word select wrong");
  alt_sel_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (active && disk && alt_regs) |-> card_select_low_lane_n
      && !card_select_high_lane_n)
    else $error("alternate register select wrong");
  rsp_time_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (req_valid && req_ready) |-> ##[36:40] rsp_valid)
    else $error("read answer late");
  master_slave_select_n_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !disk |-> master_slave_select_oe_n)
    else $error("cable select driven outside disk mode");
  insert_a: assert property (
    @(posedge clock) disable iff (!rstn)
    stat.inserted |-> !$past(card_detect_one_n, 2))
    else $error("insert status wrong");
  mode_sel_a: assert property (
    @(posedge clock) disable iff (!rstn)
    disk == !disk_mode_select_n)
    else $error("mode select pin wrong");
  word_c: cover property (@(posedge clock) rsp_valid && !disk);
  disk_c: cover property (@(posedge clock) rsp_valid && disk);
  ack_c:  cover property (@(posedge clock) rsp_valid && rsp_ack_seen);
endmodule : fchpl_host

// ==== testbench/fchpl_card_model.sv ====
`timescale 1ns/1ps
module fchpl_card_model
  import fchpl_pkg::*;
(
  input  wire logic        clock,     // System clock
  input  wire fchpl_mode_t mode,      // Card personality
  input  wire logic        cfg,       // Interface set up
  input  wire logic        slow,      // Late data
  input  wire logic        flag,      // Status pin level
  input  wire logic [10:0] a,         // Address pins
  input  wire logic        sel_lo_n,  // First select
  input  wire logic        sel_hi_n,  // Second select
  input  wire logic        io_rd_n,   // I/O read strobe
  input  wire logic        mem_rd_n,  // Memory read strobe
  input  wire logic        cable_sel, // Cable select wire level
  output logic [15:0]      d,         // Data bus
  output logic             ack_n,     // Input acknowledge
  output logic             p46,       // Battery one, status, diag
  output logic             p45,       // Battery two, audio, active
  output logic             det1_n,    // Detect one
  output logic             det2_n,    // Detect two
  output logic             as_master  // Card took master role
);
  logic [15:0] last_r = 16'h0000;
  logic [5:0]  cnt_r = 6'h00;
  logic        disk, io, rd, lo_en, hi_en;
  logic [10:0] idx;
  logic [7:0]  lo_v, hi_v;
  function automatic logic [7:0] f(input logic [10:0] x);
    return x[7:0] ^ 8'h5A;
  endfunction : f
  assign disk = mode == FCHPL_DISK;
  assign io = mode == FCHPL_IO;
  // Slow card withholds data for the first eleven strobe cycles
  assign rd = (!sel_lo_n || !sel_hi_n) && (!slow || cnt_r > 6'h0A) &&
              ((io || disk) ? !io_rd_n && cfg : !mem_rd_n);
  assign idx = disk ? {7'h00, !sel_hi_n, a[2:0]} : a;
  assign lo_en = rd && (disk || !sel_lo_n);
  assign hi_en = rd && (disk || !sel_hi_n);
  assign lo_v = disk ? f(idx) : f({a[10:1], a[0] & sel_hi_n});
  assign hi_v = disk ? ~f(idx) : f({a[10:1], 1'b1});
  // Undriven lanes toggle so stale data can never pass
  assign d = {hi_en ? hi_v : ~last_r[15:8],
              lo_en ? lo_v : ~last_r[7:0]};
  assign ack_n = !(io && rd);
  assign p46 = (io || disk) ? !flag : 1'b1;
  assign p45 = disk ? !flag : 1'b1;
  assign det1_n = 1'b0;
  assign det2_n = 1'b0;
  assign as_master = disk && !cable_sel;
  always @(posedge clock) begin
    last_r <= d;
    cnt_r <= (io_rd_n && mem_rd_n) ? 6'h00 : cnt_r + (cnt_r != 6'h3F);
  end
endmodule : fchpl_card_model

// ==== testbench/fchpl_host_test.sv ====
`timescale 1ns/1ps
module fchpl_host_test;
  import fchpl_pkg::*;
  logic clock, rstn, if_ready, is_master, alt_regs, req_valid, flag, slow;
  fchpl_mode_t mode;
  fchpl_req_t req;
  fchpl_stat_t stat;
  logic req_ready, rsp_valid, rsp_ack_seen, as_master, msel;
  logic [15:0] rsp_data, data_i;
  logic [10:0] addr_o, p_a;
  logic sl_n, sh_n, io_rd_n, memrd_n, dsel_n, attr_n, ms_n, ms_oe_n;
  logic ack_n, p46, p45, det1_n, det2_n;
  logic p_lo, p_hi, p_io, p_mem, p_at, p_ds, p_oe, p_ack;
  int errors = 0;
  int checks = 0;
  assign msel = ms_oe_n ? 1'b1 : ms_n; // Pull-up while released
  fchpl_host u_fchpl_host (.clock(clock), .rstn(rstn), .mode(mode),
    .if_ready(if_ready), .is_master(is_master), .alt_regs(alt_regs),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack_seen(rsp_ack_seen), .stat(stat), .addr_o(addr_o),
    .card_select_low_lane_n(sl_n), .card_select_high_lane_n(sh_n),
    .io_read_strobe_n(io_rd_n), .mem_read_n(memrd_n),
    .disk_mode_select_n(dsel_n), .attr_select_n(attr_n),
    .master_slave_select_n(ms_n), .master_slave_select_oe_n(ms_oe_n),
    .data_i(data_i), .input_acknowledge_n(ack_n),
    .battery_status_one(p46), .battery_status_two(p45),
    .card_detect_one_n(det1_n), .card_detect_two_n(det2_n));
  fchpl_card_model u_fchpl_card_model (.clock(clock), .mode(mode),
    .cfg(if_ready), .slow(slow), .flag(flag), .a(addr_o),
    .sel_lo_n(sl_n), .sel_hi_n(sh_n), .io_rd_n(io_rd_n),
    .mem_rd_n(memrd_n), .cable_sel(msel), .d(data_i), .ack_n(ack_n),
    .p46(p46), .p45(p45), .det1_n(det1_n), .det2_n(det2_n),
    .as_master(as_master));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Pins are captured in the last strobe cycle, answer at the rsp_valid cycle
  task automatic rd(input logic [10:0] a, input logic at,
                    input fchpl_width_t w, input logic [7:0] lo);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, attr: at, width: w};
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    @(posedge clock);
    req_valid <= 1'b0;
    {p_io, p_mem} = 2'b00;
    do begin
      @(negedge clock);
      if (!io_rd_n || !memrd_n)
        {p_a, p_lo, p_hi, p_io, p_mem, p_at, p_ds, p_oe} =
          {addr_o, sl_n, sh_n, !io_rd_n, !memrd_n, attr_n, dsel_n, ms_oe_n};
      n++;
    end while (rsp_valid !== 1'b1 && n < 150);
    p_ack = rsp_ack_seen;
    if (n >= 150) begin
      errors++;
      $display("Error at %0t: no answer", $time);
    end
    check(rsp_data[7:0], lo);
    @(posedge clock);
  endtask : rd
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mem;
    mode <= FCHPL_MEM;
    flag <= 1'b1;
    rd(11'h7FE, 1'b1, FCHPL_WORD, 8'hA4);
    check(rsp_data[15:8], 8'hA5);
    check(p_a, 11'h7FE);
    check({p_lo, p_hi, p_at}, 3'b000);
    check({p_mem, p_io, p_ack, p_oe}, 4'b1001);
    rd(11'h401, 1'b0, FCHPL_BYTE, 8'h5B);
    check({p_a, p_lo, p_hi, p_at}, {11'h401, 3'b011});
    rd(11'h123, 1'b0, FCHPL_ODD, 8'h79);
    check({p_lo, p_hi}, 2'b10);
    check({stat.battery_one, stat.battery_two, stat.inserted}, 3'b111);
  endtask : t_mem
  task automatic t_io;
    mode <= FCHPL_IO;
    if_ready <= 1'b0;
    slow <= 1'b1;
    repeat (3) @(posedge clock);
    check(req_ready, 1'b0);
    if_ready <= 1'b1;
    rd(11'h010, 1'b1, FCHPL_WORD, 8'h4A);
    check({p_io, p_mem, p_at, p_ack}, 4'b1001);
    check(stat.status_change, 1'b1);
    flag <= 1'b0;
    slow <= 1'b0;
    repeat (4) @(posedge clock);
    check(stat.status_change, 1'b0);
  endtask : t_io
  task automatic t_disk;
    mode <= FCHPL_DISK;
    if_ready <= 1'b0;
    repeat (3) @(posedge clock);
    check(req_ready, 1'b0);
    if_ready <= 1'b1;
    rd(11'h7FD, 1'b1, FCHPL_WORD, 8'h5F);
    check({p_a, p_lo, p_hi, p_io, p_ds}, {11'h005, 4'b0110});
    check({p_oe, msel, as_master}, 3'b001);
    check({stat.slave_present, stat.diag_pass, p_ack}, 3'b000);
    alt_regs <= 1'b1;
    is_master <= 1'b0;
    flag <= 1'b1;
    rd(11'h7FD, 1'b0, FCHPL_WORD, 8'h57);
    check({p_lo, p_hi, p_oe, msel, as_master}, 5'b10110);
    check({stat.slave_present, stat.diag_pass}, 2'b11);
  endtask : t_disk
  // ---------------------------------------------------------------
  // Clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {rstn, if_ready, is_master, alt_regs, req_valid, flag, slow} = 7'h10;
    mode = FCHPL_MEM;
    req = '0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_mem;
    t_io;
    t_disk;
    results;
  end
  // Whole run is near 260 cycles; allow over thirty times that
  initial begin
    #50000;
    errors++;
    results;
  end
endmodule : fchpl_host_test
